// [rtl/aalu_top.sv]
`default_nettype none

// Accumulator datapath with AHB-Lite register access.
module aalu_top (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Register file port.
    output logic [6:0] rf_addr,
    output logic [7:0] rf_wdata,
    output logic rf_we,
    input wire logic [7:0] rf_rdata,
    // Power control.
    output logic osc_stop,
    output logic wdog_clear,
    input wire logic wake
);
    import aalu_pkg::*;

    aalu_if alu ();

    aalu_unit u_unit (
        .u(alu.unit)
    );

    logic wr_pend;
    logic rd_pend;
    logic [7:0] a_addr;
    logic [31:0] cmd;
    logic [7:0] acc;
    logic carry;
    logic half;
    logic zero;
    logic power_down_flag;
    logic expiry_flag;
    logic asleep;
    logic [7:0] result;
    logic [7:0] wdog_counter;
    logic [3:0] wdog_presc;
    logic go;
    logic [1:0] phase;
    logic dest_reg;
    aalu_op_t op;

    ////////////////////////////////////////////////////////////////////////
    // Address phase capture; zero wait states, always OKAY.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            a_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            rd_pend <= hsel && htrans[1] && !hwrite;
            a_addr <= haddr;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // Read data register, loaded during the address phase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr)
                ADDR_CMD: hrdata <= cmd;
                ADDR_ACC: hrdata <= {24'h00_0000, acc};
                ADDR_STATUS: hrdata <= {26'h000_0000, asleep, expiry_flag, power_down_flag, zero, half, carry};
                ADDR_RESULT: hrdata <= {16'h0000, wdog_counter, result};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command register; writing it while awake with phase 0 launches the operation.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd <= 32'h0000_0000;
            go <= 1'b0;
        end else begin
            go <= wr_pend && (a_addr == ADDR_CMD) && !asleep && (phase == 2'h0);
            if (wr_pend && (a_addr == ADDR_CMD)) begin
                cmd <= hwdata;
            end
        end
    end

    always_comb begin
        op = aalu_op_t'(cmd[CMD_OP_LSB +: 3]);
        dest_reg = cmd[CMD_DEST_BIT];
    end

    // Register-operand ops: phase 1 reads file, phase 2 executes.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase <= 2'h0;
        end else if (go) begin
            phase <= 2'h1;
        end else if (phase == 2'h1) begin
            phase <= 2'h2;
        end else begin
            phase <= 2'h0;
        end
    end

    // Operand steering into the compute unit.
    always_comb begin
        alu.op = op;
        alu.acc = acc;
        alu.carry_in = carry;
        if (op == AALU_OP_SUBL || op == AALU_OP_XORL) begin
            alu.src = cmd[CMD_LIT_LSB +: 8];
        end else begin
            alu.src = rf_rdata;
        end
    end

    // Register file address stays on the commanded operand.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rf_addr <= 7'h00;
        end else if (go) begin
            rf_addr <= cmd[CMD_ADDR_LSB +: 7];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result write-back and flag update at execute.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc <= ACC_RESET;
            carry <= 1'b0;
            half <= 1'b0;
            zero <= 1'b0;
            result <= 8'h00;
            rf_we <= 1'b0;
            rf_wdata <= 8'h00;
        end else begin
            rf_we <= 1'b0;
            if (wr_pend && a_addr == ADDR_ACC) begin
                acc <= hwdata[7:0];
            end
            if (phase == 2'h2 && op != AALU_OP_NONE && op != AALU_OP_HALT) begin
                result <= alu.result;
                if (dest_reg && op != AALU_OP_SUBL && op != AALU_OP_XORL) begin
                    rf_we <= 1'b1;
                    rf_wdata <= alu.result;
                end else begin
                    acc <= alu.result;
                end
                if (op == AALU_OP_SUBL || op == AALU_OP_SUBF || op == AALU_OP_ROTR) begin
                    carry <= alu.carry_out;
                end
                if (op == AALU_OP_SUBL || op == AALU_OP_SUBF) begin
                    half <= alu.half_out;
                end
                if (op != AALU_OP_ROTR && op != AALU_OP_SWAP) begin
                    zero <= alu.zero_out;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Halt handling: flags, watchdog, sleep.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_down_flag <= 1'b1;
            expiry_flag <= 1'b1;
            asleep <= 1'b0;
            osc_stop <= 1'b0;
            wdog_clear <= 1'b0;
            wdog_counter <= WDOG_CLEAR;
            wdog_presc <= PRESC_CLEAR;
        end else begin
            wdog_clear <= 1'b0;
            if (phase == 2'h2 && op == AALU_OP_HALT) begin
                power_down_flag <= 1'b0;
                expiry_flag <= 1'b1;
                wdog_counter <= WDOG_CLEAR;
                wdog_presc <= PRESC_CLEAR;
                wdog_clear <= 1'b1;
                asleep <= 1'b1;
                osc_stop <= 1'b1;
            end else if (asleep && (wake || (wr_pend && a_addr == ADDR_WAKE))) begin
                asleep <= 1'b0;
                osc_stop <= 1'b0;
            end else if (!asleep) begin
                {wdog_counter, wdog_presc} <= {wdog_counter, wdog_presc} + 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // a_halt_flags: halt leaves power flags in defined state.
    // power flags
    a_halt_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_HALT) |=> (!power_down_flag && expiry_flag && $stable(carry)))
        else $error("halt flags wrong");
    a_halt_wdog: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_HALT) |=> (wdog_counter == 8'h00 && wdog_presc == 4'h0 && wdog_clear))
        else $error("watchdog not cleared");
    a_sleep_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (asleep && !wake && !(wr_pend && a_addr == ADDR_WAKE)) |=> (asleep && osc_stop && phase == 2'h0))
        else $error("sleep left without wake");
    a_rotate_res: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_ROTR) |=> (result == {$past(carry), $past(rf_rdata[7:1])}
        && carry == $past(rf_rdata[0]) && $stable(zero)))
        else $error("rotate wrong");
    a_dest_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_XORF && dest_reg) |=> (rf_we && $stable(acc)))
        else $error("destination wrong");
    a_lit_sub: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_SUBL) |=> (acc == 8'($past(cmd[23:16]) - $past(acc))))
        else $error("literal subtract wrong");
    a_sub_carry: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_SUBF) |=> (carry == ($past(acc) <= $past(rf_rdata))))
        else $error("subtract carry wrong");
    a_reg_sub: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_SUBF) |=> (result == 8'($past(rf_rdata) - $past(acc))))
        else $error("register subtract wrong");
    a_xor_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_XORL) |=> ($stable(carry) && $stable(half)))
        else $error("xor changed carry");
    a_swap_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_SWAP) |=> ($stable(zero) && $stable(carry) && $stable(half)))
        else $error("swap touched flags");
    a_zero_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && (op == AALU_OP_XORF || op == AALU_OP_SUBF)) |=> (zero == (result == 8'h00)))
        else $error("zero flag wrong");

    ////////////////////////////////////////////////////////////////////////
    // Further guards on operand use, sleep gating and the bus answer.
    // half-borrow meaning
    a_sub_half: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_SUBL) |=> (half == ($past(acc[3:0]) <= $past(cmd[CMD_LIT_LSB +: 4]))))
        else $error("literal subtract half-borrow wrong");
    a_lit_xor: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_XORL) |=> (acc == ($past(acc) ^ $past(cmd[CMD_LIT_LSB +: 8]))))
        else $error("literal xor wrong");
    a_reg_xor: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_XORF && !dest_reg) |=> (acc == ($past(acc) ^ $past(rf_rdata))
        && $stable(carry) && $stable(half)))
        else $error("register xor wrong");
    a_swap_res: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && op == AALU_OP_SWAP) |=> (result == {$past(rf_rdata[3:0]), $past(rf_rdata[7:4])}))
        else $error("nibble exchange wrong");
    a_dest_acc: assert property (@(posedge hclk) disable iff (!hresetn)
        (phase == 2'h2 && (op == AALU_OP_SUBF || op == AALU_OP_ROTR || op == AALU_OP_SWAP) && !dest_reg)
        |=> !rf_we)
        else $error("accumulator destination wrote file");
    a_sleep_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        asleep |-> !go)
        else $error("command launched while asleep");
    a_wake_exit: assert property (@(posedge hclk) disable iff (!hresetn)
        (asleep && wake) |=> (!asleep && !osc_stop))
        else $error("wake did not end sleep");
    // The bus answer is always zero-wait and okay.
    a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
        (wr_pend || rd_pend) |-> (hreadyout && !hresp))
        else $error("bus answer not ready or okay");

endmodule : aalu_top

`default_nettype wire

// [rtl/aalu_pkg.sv]
`default_nettype none

package aalu_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map, one aligned word per register.
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_OPERAND = 8'h04;
    localparam logic [7:0] ADDR_ACC = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_WAKE = 8'h14;

    // Command register fields.
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_DEST_BIT = 4;
    localparam int CMD_ADDR_LSB = 8;
    localparam int CMD_LIT_LSB = 16;

    // Status register bit positions.
    localparam int ST_CARRY = 0;
    localparam int ST_HALF = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_POWER_DOWN = 3;
    localparam int ST_EXPIRY = 4;
    localparam int ST_ASLEEP = 5;

    // Reset values.
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] WDOG_CLEAR = 8'h00;
    localparam logic [3:0] PRESC_CLEAR = 4'h0;

    // Operation codes.
    typedef enum logic [2:0] {
        AALU_OP_NONE = 3'h0,
        AALU_OP_SUBL = 3'h1,
        AALU_OP_SUBF = 3'h2,
        AALU_OP_XORL = 3'h3,
        AALU_OP_XORF = 3'h4,
        AALU_OP_ROTR = 3'h5,
        AALU_OP_SWAP = 3'h6,
        AALU_OP_HALT = 3'h7
    } aalu_op_t;

endpackage : aalu_pkg

`default_nettype wire

// [rtl/aalu_if.sv]
`default_nettype none

// Operands into the compute unit and its result back.
interface aalu_if;
    import aalu_pkg::*;
    aalu_op_t op;
    logic [7:0] acc;
    logic [7:0] src;
    logic carry_in;
    logic [7:0] result;
    logic carry_out;
    logic half_out;
    logic zero_out;

    modport master (output op, acc, src, carry_in, input result, carry_out, half_out, zero_out);
    modport unit (input op, acc, src, carry_in, output result, carry_out, half_out, zero_out);
endinterface : aalu_if

`default_nettype wire

// [rtl/aalu_unit.sv]
`default_nettype none

// Combinational compute unit for the supported operations.
module aalu_unit (
    aalu_if.unit u
);
    import aalu_pkg::*;

    logic [8:0] diff;
    logic [4:0] diff_lo;

    ////////////////////////////////////////////////////////////////////////
    // Subtraction with borrow detection.
    always_comb begin
        diff = {1'b0, u.src} - {1'b0, u.acc};
        diff_lo = {1'b0, u.src[3:0]} - {1'b0, u.acc[3:0]};
    end

    // Result and flag selection.
    always_comb begin
        u.result = u.src;
        u.carry_out = u.carry_in;
        u.half_out = 1'b0;
        unique case (u.op)
            AALU_OP_SUBL, AALU_OP_SUBF: begin
                u.result = diff[7:0];
                u.carry_out = ~diff[8];
                u.half_out = ~diff_lo[4];
            end
            AALU_OP_XORL, AALU_OP_XORF: begin
                u.result = u.acc ^ u.src;
            end
            AALU_OP_ROTR: begin
                u.result = {u.carry_in, u.src[7:1]};
                u.carry_out = u.src[0];
            end
            AALU_OP_SWAP: begin
                u.result = {u.src[3:0], u.src[7:4]};
            end
            default: begin
                u.result = u.src;
            end
        endcase
        u.zero_out = (u.result == 8'h00);
    end

endmodule : aalu_unit

`default_nettype wire

// [dv/test_accumulator_alu_ops.sv]
`default_nettype none

`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end

module test_accumulator_alu_ops;
    timeunit 1ns;
    timeprecision 1ps;
    import aalu_pkg::*;

    typedef struct {aalu_op_t op; logic dest; logic [6:0] fa; logic [7:0] lit, acc, fv;} aalu_row_t;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [6:0] rf_addr;
    logic [7:0] rf_wdata;
    logic rf_we;
    logic [7:0] rf_rdata;
    logic osc_stop;
    logic wdog_clear;
    logic wake = 1'b0;
    logic [7:0] rf [128];
    int error_cnt = 0;
    int num_checks = 0;
    int wd_pulses = 0;
    logic [31:0] rd;
    logic [7:0] m_acc, m_res;
    logic m_c, m_hb, m_z;
    aalu_row_t rows [11] = '{
        '{AALU_OP_SUBL, 1'b0, 7'h00, 8'h05, 8'h05, 8'h00}, '{AALU_OP_SUBL, 1'b0, 7'h00, 8'h10, 8'h21, 8'h00},
        '{AALU_OP_SUBF, 1'b0, 7'h7F, 8'h00, 8'h0F, 8'h3C}, '{AALU_OP_SUBF, 1'b1, 7'h00, 8'h00, 8'h01, 8'h80},
        '{AALU_OP_XORL, 1'b0, 7'h00, 8'hA5, 8'hA5, 8'h00}, '{AALU_OP_XORF, 1'b1, 7'h55, 8'h00, 8'h0F, 8'hF0},
        '{AALU_OP_XORF, 1'b0, 7'h12, 8'h00, 8'h33, 8'h33}, '{aalu_op_t'(3'h5), 1'b1, 7'h40, 8'h00, 8'h11, 8'h81},
        '{aalu_op_t'(3'h5), 1'b0, 7'h41, 8'h00, 8'h22, 8'h02}, '{AALU_OP_SWAP, 1'b1, 7'h7F, 8'h00, 8'h44, 8'h1E},
        '{AALU_OP_SWAP, 1'b0, 7'h01, 8'h00, 8'h55, 8'hC3}};

    aalu_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_we(rf_we), .rf_rdata(rf_rdata), .osc_stop(osc_stop),
        .wdog_clear(wdog_clear), .wake(wake));

    ////////////////////////////////////////////////////////////////////////
    // The single slave's ready is the bus ready; the file answers at once.
    assign hready = hreadyout;
    assign rf_rdata = rf[rf_addr];

    // The clock toggles every 12.5 ns, half of its 25 ns period.
    always #12.5 hclk = ~hclk;

    // The register file takes the write pulse and counts watchdog clears.
    always @(posedge hclk) begin
        if (rf_we === 1'b1) rf[rf_addr] <= rf_wdata;
        if (wdog_clear === 1'b1) wd_pulses <= wd_pulses + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One single word transfer: address phase, then data phase.
    // Waits for ready as long as it takes; only the watchdog ends a hang.
    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(posedge hclk);
        end while (hready !== 1'b1);
        rd = hrdata;
    endtask : ahb

    // Launches a command and leaves it time to finish.
    task automatic cmd(input aalu_op_t op, input logic dest, input logic [6:0] fa, input logic [7:0] lit);
        ahb(1'b1, ADDR_CMD, (32'(op) << CMD_OP_LSB) | (32'(dest) << CMD_DEST_BIT) |
            (32'(fa) << CMD_ADDR_LSB) | (32'(lit) << CMD_LIT_LSB));
        repeat (8) @(posedge hclk);
    endtask : cmd

    // Expected result and flags of one operation.
    function automatic void model(input aalu_op_t op, input logic [7:0] a, input logic [7:0] s);
        m_res = a;
        if (op == AALU_OP_SUBL || op == AALU_OP_SUBF) begin
            m_res = s - a; m_c = (a <= s); m_hb = (a[3:0] <= s[3:0]); m_z = (m_res == 8'h00);
        end else if (op == AALU_OP_XORL || op == AALU_OP_XORF) begin
            m_res = a ^ s; m_z = (m_res == 8'h00);
        end else if (op == aalu_op_t'(3'h5)) begin
            m_res = {m_c, s[7:1]}; m_c = s[0];
        end else if (op == AALU_OP_SWAP) begin
            m_res = {s[3:0], s[7:4]};
        end
    endfunction : model

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////
    // Cuts a hang short well beyond the expected run.
    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        int w0;
        logic lit_op;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK({hrdata, hreadyout, hresp, osc_stop, rf_we}, {32'h0, 4'b1000})
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[5:3], 3'b011)
        ahb(1'b0, ADDR_OPERAND, 32'h0);
        `CHK(rd, 32'h0)
        ahb(1'b0, 8'h18, 32'h0);
        `CHK(rd, 32'h0)
        $display("test reset done");
        foreach (rows[i]) begin
            lit_op = (rows[i].op == AALU_OP_SUBL || rows[i].op == AALU_OP_XORL);
            rf[rows[i].fa] <= rows[i].fv;
            ahb(1'b1, ADDR_ACC, {24'h0, rows[i].acc});
            cmd(rows[i].op, rows[i].dest, rows[i].fa, rows[i].lit);
            model(rows[i].op, rows[i].acc, lit_op ? rows[i].lit : rows[i].fv);
            m_acc = (rows[i].dest && !lit_op) ? rows[i].acc : m_res;
            ahb(1'b0, ADDR_ACC, 32'h0);
            `CHK(rd[7:0], m_acc)
            `CHK(rf[rows[i].fa], (rows[i].dest && !lit_op) ? m_res : rows[i].fv)
            ahb(1'b0, ADDR_STATUS, 32'h0);
            `CHK(rd[5:0], {3'b011, m_z, m_hb, m_c})
            ahb(1'b0, ADDR_RESULT, 32'h0);
            `CHK(rd[7:0], m_res)
            $display("test row %0d done", i);
        end
        w0 = wd_pulses;
        cmd(AALU_OP_HALT, 1'b0, 7'h00, 8'h00);
        `CHK(wd_pulses, w0 + 1)
        `CHK(osc_stop, 1'b1)
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[5:0], {3'b110, m_z, m_hb, m_c})
        ahb(1'b0, ADDR_RESULT, 32'h0);
        `CHK(rd[15:8], WDOG_CLEAR)
        cmd(AALU_OP_XORL, 1'b0, 7'h00, 8'hFF);
        ahb(1'b0, ADDR_ACC, 32'h0);
        `CHK(rd[7:0], m_acc)
        wake <= 1'b1;
        repeat (2) @(posedge hclk);
        wake <= 1'b0;
        repeat (4) @(posedge hclk);
        `CHK(osc_stop, 1'b0)
        cmd(AALU_OP_XORL, 1'b0, 7'h00, 8'h0F);
        ahb(1'b0, ADDR_ACC, 32'h0);
        `CHK(rd[7:0], m_acc ^ 8'h0F)
        $display("test halt done");
        // A write to the wake register also ends sleep; a no-op leaves the accumulator.
        cmd(AALU_OP_HALT, 1'b0, 7'h00, 8'h00);
        `CHK(osc_stop, 1'b1)
        ahb(1'b1, ADDR_WAKE, 32'h0);
        @(posedge hclk);
        `CHK(osc_stop, 1'b0)
        cmd(AALU_OP_NONE, 1'b0, 7'h00, 8'hFF);
        ahb(1'b0, ADDR_ACC, 32'h0);
        `CHK(rd[7:0], m_acc ^ 8'h0F)
        $display("test wake write done");
        // A reset taken while asleep restarts the core awake.
        cmd(AALU_OP_HALT, 1'b0, 7'h00, 8'h00);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        `CHK(osc_stop, 1'b0)
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        `CHK(rd[5:3], 3'b011)
        $display("test reset in sleep done");
        print_verdict();
    end
endmodule : test_accumulator_alu_ops

`undef CHK

`default_nettype wire
